/* bench/bms_host_model.sv */
// host model: raises the host-to-cpu interrupt after a set wait
`timescale 1ns/100ps
`default_nettype none
module bms_host_model (
	input  wire logic       sys_clk_in,
	input  wire logic       start_in,
	input  wire logic [7:0] wait_in,
	output logic            irq_out
);
	initial irq_out = 1'b0;
	// dropped again so that the next request gives a fresh edge
	always @(posedge start_in) begin
		repeat (wait_in) @(posedge sys_clk_in);
		#1 irq_out = 1'b1;
		repeat (6) @(posedge sys_clk_in);
		#1 irq_out = 1'b0;
	end
endmodule
`default_nettype wire

/* bench/bms_top_monitor.sv */
// checker: port-level properties of the boot mode sequencer
`timescale 1ns/100ps
`default_nettype none
module bms_top_monitor
	import bms_pkg::*;
(
	input  wire logic          sys_clk_in,
	input  wire logic          sys_rst_in,
	input  wire logic          host_access_in,
	input  wire logic [31:0]   host_addr_in,
	input  wire logic [31:0]   sys_addr_in,
	input  var  bms_pkg::bms_cpu_t  cpu_ctrl_out,
	input  var  bms_pkg::bms_pll_t  pll_ctrl_out,
	input  var  bms_pkg::bms_dec_t  dec_out,
	input  var  bms_pkg::bms_mode_t boot_mode_out,
	input  wire logic          boot_done_out,
	input  wire logic          host_access_block_out,
	input  wire logic          host_irq_flag_out,
	input  wire logic          dma_event0_out
);
	wire logic host_m = boot_mode_out inside {BMS_MODE_HOST_HPP, BMS_MODE_HOST_PCI};
	wire logic cfg_hit = (host_addr_in & BMS_DSC_MASK) == BMS_DSC_BASE;

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);

	a_boot_starts: assert property (
		$fell(sys_rst_in) |-> ##[1:8] (boot_mode_out != BMS_MODE_NONE || !cpu_ctrl_out.cpu_reset))
		else $error("boot did not start after reset");
	a_none_entry: assert property (
		boot_mode_out == BMS_MODE_NONE && !cpu_ctrl_out.cpu_reset |-> cpu_ctrl_out.fetch_addr == BMS_L2_ENTRY)
		else $error("no-boot entry wrong");
	a_host_stall: assert property (
		host_m && !boot_done_out |-> cpu_ctrl_out.cpu_stall) else $error("host boot cpu not stalled");
	a_hpp_reset: assert property (
		boot_mode_out == BMS_MODE_HOST_HPP && !boot_done_out |-> cpu_ctrl_out.cpu_reset)
		else $error("host port boot cpu out of reset");
	a_block_cfg: assert property (
		host_access_in && host_m && !boot_done_out && cfg_hit |-> ##2 host_access_block_out)
		else $error("state control access not blocked");
	a_release_run: assert property (
		$rose(boot_done_out) && host_m |-> cpu_ctrl_out.fetch_addr == BMS_L2_ENTRY
		&& !cpu_ctrl_out.cpu_stall && !cpu_ctrl_out.cpu_reset && host_irq_flag_out)
		else $error("host release wrong");
	a_event_latch: assert property (
		$rose(host_irq_flag_out) |-> dma_event0_out) else $error("event bit not latched");
	a_no_rearm: assert property (
		$rose(dma_event0_out) |-> $rose(host_irq_flag_out)) else $error("event without new flag");
	a_pll_pci: assert property (
		pll_ctrl_out.load |-> pll_ctrl_out.mult == BMS_PLL_MULT_PCI && pll_ctrl_out.pll_predivider_reg == 5'h00
		&& boot_mode_out == BMS_MODE_HOST_PCI) else $error("pll load wrong");
	a_rom8_entry: assert property (
		boot_mode_out == BMS_MODE_ROM8 |-> cpu_ctrl_out.fetch_addr == BMS_CS3_ENTRY && !cpu_ctrl_out.cpu_reset)
		else $error("rom boot entry wrong");
	a_loader_entry: assert property (
		boot_mode_out inside {BMS_MODE_I2C_MST, BMS_MODE_I2C_SLV} |-> cpu_ctrl_out.bootloader_run
		&& cpu_ctrl_out.fetch_addr == BMS_ROM_ENTRY) else $error("loader entry wrong");
	a_rsvd_halt: assert property (
		boot_mode_out == BMS_MODE_RSVD |-> cpu_ctrl_out.cpu_reset && !boot_done_out)
		else $error("reserved code did not halt");
	a_pci_window: assert property (
		sys_addr_in[31:28] == 4'h4 |=> dec_out.pci) else $error("pci window missed");

	c_host_release: cover property ($rose(boot_done_out) && host_m);
	c_pll_load: cover property (pll_ctrl_out.load);
	c_blocked: cover property (host_access_block_out);
endmodule
bind bms_top bms_top_monitor u_mon (.*);
`default_nettype wire

/* bench/bms_top_test.sv */
// testbench: boot modes, host release, access gating and address decode
`timescale 1ns/100ps
`default_nettype none
module bms_top_test;
	import bms_pkg::*;
	logic        sys_clk_in = 1'h0;
	logic        sys_rst_in = 1'h1;
	logic        pci_sel    = 1'h0;
	logic        flag_clr   = 1'h0;
	logic        evt_clr    = 1'h0;
	logic        hacc       = 1'h0;
	logic        go         = 1'h0;
	logic        irq;
	logic [3:0]  sel        = 4'h0;
	logic [2:0]  cfg        = 3'h0;
	logic [7:0]  wt         = 8'h00;
	logic [31:0] haddr      = 32'h0;
	logic [31:0] saddr      = 32'h0;
	bms_cpu_t    cpu;
	bms_pll_t    pll;
	bms_dec_t    dec;
	bms_mode_t   mode;
	logic        done, grant, block, flag, evt, cerr;
	int          n_errors   = 0;
	int          n_compared = 0;

	always #20 sys_clk_in = ~sys_clk_in;

	bms_top dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .boot_select_pins_in(sel),
		.pci_select_pin_in(pci_sel), .general_config_pins_in(cfg), .host_to_cpu_interrupt_in(irq),
		.host_irq_flag_clear_in(flag_clr), .dma_event_clear_in(evt_clr), .host_access_in(hacc),
		.host_addr_in(haddr), .sys_addr_in(saddr), .cpu_ctrl_out(cpu), .pll_ctrl_out(pll),
		.dec_out(dec), .boot_mode_out(mode), .boot_done_out(done), .host_access_grant_out(grant),
		.host_access_block_out(block), .host_irq_flag_out(flag), .dma_event0_out(evt),
		.config_error_out(cerr));
	bms_host_model host (.sys_clk_in(sys_clk_in), .start_in(go), .wait_in(wt), .irq_out(irq));

	task tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task boot(input logic [3:0] s, input logic p);
		sys_rst_in = 1'h1;
		sel = s;
		pci_sel = p;
		cfg = 3'h0;
		tick(12);
		sys_rst_in = 1'h0;
		tick(10);
	endtask
	task access(input logic [31:0] a, input logic b);
		hacc = 1'h1;
		haddr = a;
		tick(1);
		hacc = 1'h0;
		tick(1);
		chk("block", b, block);
		chk("grant", !b, grant);
	endtask
	task raise(input logic [7:0] w);
		wt = w;
		go = 1'h1;
		tick(1);
		go = 1'h0;
		tick(w + 10);
	endtask

	task t_direct;
		boot(BMS_SEL_NONE, 1'h0);
		chk("none reset", 1'h0, cpu.cpu_reset);
		chk("none fetch", BMS_L2_ENTRY, cpu.fetch_addr);
		access(32'h02AC_0000, 1'h0);
		boot(BMS_SEL_ROM8, 1'h0);
		chk("rom8 fetch", BMS_CS3_ENTRY, cpu.fetch_addr);
		boot(BMS_SEL_I2C_MST, 1'h0);
		chk("mst mode", BMS_MODE_I2C_MST, mode);
		chk("mst fetch", BMS_ROM_ENTRY, cpu.fetch_addr);
		boot(BMS_SEL_I2C_SLV, 1'h0);
		chk("slv mode", BMS_MODE_I2C_SLV, mode);
		chk("slv loader", 1'h1, cpu.bootloader_run);
		boot(4'h3, 1'h0);
		chk("rsvd mode", BMS_MODE_RSVD, mode);
		chk("rsvd reset", 1'h1, cpu.cpu_reset);
		boot(BMS_SEL_HOST_PCI, 1'h0);
		chk("pci strap error", 1'h1, cerr);
		boot(BMS_SEL_HOST_HPP, 1'h1);
		chk("hpp strap error", 1'h1, cerr);
	endtask

	task t_hpp;
		boot(BMS_SEL_HOST_HPP, 1'h0);
		chk("hpp reset", 1'h1, cpu.cpu_reset);
		chk("hpp stall", 1'h1, cpu.cpu_stall);
		chk("hpp strap", 1'h0, cerr);
		access(32'h02AC_0010, 1'h1);
		access(32'h029A_01FC, 1'h1);
		access(32'h029C_0000, 1'h1);
		access(32'h029A_0200, 1'h0);
		access(32'h0080_0000, 1'h0);
		raise(8'h02);
		chk("hpp run", 1'h1, done);
		chk("hpp fetch", BMS_L2_ENTRY, cpu.fetch_addr);
		chk("hpp flag", 1'h1, flag);
		chk("event", 1'h1, evt);
		evt_clr = 1'h1;
		tick(1);
		evt_clr = 1'h0;
		chk("event clear", 1'h0, evt);
		raise(8'h02);
		chk("event refused", 1'h0, evt);
		flag_clr = 1'h1;
		tick(1);
		flag_clr = 1'h0;
		chk("flag clear", 1'h0, flag);
		raise(8'h02);
		chk("event again", 1'h1, evt);
	endtask

	task t_pci;
		boot(BMS_SEL_HOST_PCI, 1'h1);
		chk("pci mode", BMS_MODE_HOST_PCI, mode);
		chk("pci reset", 1'h0, cpu.cpu_reset);
		chk("pci idle", 1'h1, cpu.cpu_idle_wait);
		chk("pci strap", 1'h0, cerr);
		chk("pll mult", BMS_PLL_MULT_PCI, pll.mult);
		chk("pll divider", 5'h00, pll.pll_predivider_reg);
		access(32'h02AF_FFFC, 1'h1);
		raise(8'h28);
		chk("pci run", 1'h1, done);
		chk("pci fetch", BMS_L2_ENTRY, cpu.fetch_addr);
	endtask

	task t_decode;
		logic [40:0] tbl [16];
		tbl = '{{32'h4000_0000, 9'h100}, {32'h4FFF_FFFC, 9'h100}, {32'h5000_0000, 9'h000},
			{32'h7000_0000, 9'h080}, {32'h77FF_FFFF, 9'h080}, {32'h7800_0000, 9'h040},
			{32'h8000_0000, 9'h000}, {32'h9FFF_FFFF, 9'h000}, {32'hA07F_FFFF, 9'h004},
			{32'hA080_0000, 9'h000}, {32'hB000_0000, 9'h008}, {32'hC07F_FFFF, 9'h010},
			{32'hD000_0000, 9'h020}, {32'hDFFF_FFFF, 9'h000}, {32'hE000_0000, 9'h002},
			{32'hFFFF_FFFF, 9'h002}};
		foreach (tbl[i]) begin
			saddr = tbl[i][40:9];
			tick(1);
			chk("decode", tbl[i][8:0], dec);
		end
	endtask

	task summarize;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		t_direct();
		t_hpp();
		t_pci();
		t_decode();
		summarize();
	end
	initial begin
		repeat (3000) @(posedge sys_clk_in);
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire

/* hw/bms_addr_dec.sv */
// registered upper system address decoder
`timescale 1ns/100ps
`default_nettype none
module bms_addr_dec
	import bms_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic [31:0] addr_in,
	output bms_pkg::bms_dec_t dec_out
);
	bms_dec_t dec_d;
	bms_dec_t dec_q;

	function automatic logic hit(input logic [31:0] a, input logic [31:0] base, input logic [31:0] mask);
		hit = ((a & mask) == (base & mask));
	endfunction

	assign dec_d.pci       = hit(addr_in, BMS_PCI_BASE, BMS_PCI_MASK);     // [RULE20]
	assign dec_d.async_cfg = hit(addr_in, BMS_ASYNC_BASE, BMS_CFG_MASK);   // [RULE21]
	assign dec_d.ddr_cfg   = hit(addr_in, BMS_DDRC_BASE, BMS_CFG_MASK);    // [RULE21]
	assign dec_d.ddr       = hit(addr_in, BMS_DDR_BASE, BMS_DDR_MASK);     // [RULE19]
	assign dec_d.blocked_cfg = hit(addr_in, BMS_DSC_BASE, BMS_DSC_MASK)
		| hit(addr_in, BMS_PLL1_BASE, BMS_PLL_MASK)
		| hit(addr_in, BMS_PLL2_BASE, BMS_PLL_MASK);

	// chip selects 2..5 only; 0 and 1 get no window
	genvar g;
	generate
		for (g = 0; g < BMS_NUM_CS; g++) begin : g_cs
			localparam logic [31:0] CS_BASE = BMS_CS2_BASE + 32'(g) * BMS_CS_STEP;
			assign dec_d.cs[g] = hit(addr_in, CS_BASE, BMS_CS_MASK); // [RULE18] [RULE22]
		end
	endgenerate

	assign dec_out = dec_q;

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			dec_q <= '0;
		end else begin
			dec_q <= dec_d;
		end
	end
endmodule
`default_nettype wire

/* hw/bms_pkg.sv */
// package: boot mode sequencer constants and carrier types
package bms_pkg;

	// ------------------------------------------------------------------
	// boot select encodings
	// ------------------------------------------------------------------
	localparam logic [3:0] BMS_SEL_NONE     = 4'h0;
	localparam logic [3:0] BMS_SEL_HOST_HPP = 4'h1;
	localparam logic [3:0] BMS_SEL_ROM8     = 4'h4;
	localparam logic [3:0] BMS_SEL_I2C_MST  = 4'h5;
	localparam logic [3:0] BMS_SEL_I2C_SLV  = 4'h6;
	localparam logic [3:0] BMS_SEL_HOST_PCI = 4'h7;

	// ------------------------------------------------------------------
	// fetch vectors
	// ------------------------------------------------------------------
	localparam logic [31:0] BMS_L2_ENTRY   = 32'h0080_0000;
	localparam logic [31:0] BMS_ROM_ENTRY  = 32'h0010_0000;
	localparam logic [31:0] BMS_CS3_ENTRY  = 32'hB000_0000;

	// ------------------------------------------------------------------
	// pll settings for pci boot
	// ------------------------------------------------------------------
	localparam logic [4:0] BMS_PLL_MULT_PCI   = 5'h0E;
	localparam logic [4:0] BMS_PLL_PLL_PREDIVIDER_REG_PCI = 5'h00;
	localparam logic [2:0] BMS_CFG_PINS_PCI   = 3'h0;

	// ------------------------------------------------------------------
	// address windows: base, mask of compared bits
	// ------------------------------------------------------------------
	localparam logic [31:0] BMS_PCI_BASE   = 32'h4000_0000;
	localparam logic [31:0] BMS_PCI_MASK   = 32'hF000_0000;
	localparam logic [31:0] BMS_ASYNC_BASE = 32'h7000_0000;
	localparam logic [31:0] BMS_DDRC_BASE  = 32'h7800_0000;
	localparam logic [31:0] BMS_CFG_MASK   = 32'hF800_0000;
	localparam logic [31:0] BMS_CS2_BASE   = 32'hA000_0000;
	localparam logic [31:0] BMS_CS_STEP    = 32'h1000_0000;
	localparam logic [31:0] BMS_CS_MASK    = 32'hFF80_0000;
	localparam logic [31:0] BMS_DDR_BASE   = 32'hE000_0000;
	localparam logic [31:0] BMS_DDR_MASK   = 32'hE000_0000;
	localparam logic [31:0] BMS_DSC_BASE   = 32'h02AC_0000;
	localparam logic [31:0] BMS_DSC_MASK   = 32'hFFFC_0000;
	localparam logic [31:0] BMS_PLL1_BASE  = 32'h029A_0000;
	localparam logic [31:0] BMS_PLL2_BASE  = 32'h029C_0000;
	localparam logic [31:0] BMS_PLL_MASK   = 32'hFFFF_FE00;
	localparam int          BMS_NUM_CS     = 4;

	// edges spent letting the strap synchronisers fill after reset
	localparam logic [1:0]  BMS_SETTLE_CYCLES = 2'h3;

	// ------------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		BMS_MODE_NONE,
		BMS_MODE_HOST_HPP,
		BMS_MODE_HOST_PCI,
		BMS_MODE_ROM8,
		BMS_MODE_I2C_MST,
		BMS_MODE_I2C_SLV,
		BMS_MODE_RSVD
	} bms_mode_t;

	typedef struct packed {
		logic                  pci;
		logic                  async_cfg;
		logic                  ddr_cfg;
		logic [BMS_NUM_CS-1:0] cs;
		logic                  ddr;
		logic                  blocked_cfg;
	} bms_dec_t;

	typedef struct packed {
		logic        cpu_reset;
		logic        cpu_stall;
		logic        cpu_idle_wait;
		logic [31:0] fetch_addr;
		logic        bootloader_run;
	} bms_cpu_t;

	typedef struct packed {
		logic [4:0] mult;
		logic [4:0] pll_predivider_reg;
		logic       load;
	} bms_pll_t;

endpackage

/* hw/bms_sync3.sv */
// three-stage synchroniser for pin inputs, change accepted when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module bms_sync3 #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] lvl_q;
	logic [WIDTH-1:0] lvl_d;

	// a zero-width synchroniser has nothing to carry
	if (WIDTH < 1) begin : g_width_check
		$error("bms_sync3: WIDTH must be at least 1");
	end

	assign lvl_d     = (s2_q == s3_q) ? s3_q : lvl_q;
	assign level_out = lvl_q;

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			lvl_q <= '0;
		end else begin
			s1_q  <= pin_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end
endmodule
`default_nettype wire

/* hw/bms_top.sv */
// boot mode sequencer: boot select capture, cpu release, host gating, decode
// Behaviour
// [RULE1] boot starts by itself after every reset
// [RULE2] select 0000b runs from L2 at 0x800000
// [RULE3] host boot stalls CPU, releases rest
// [RULE4] host boot blocks state-control and PLL accesses
// [RULE5] host interrupt releases stall, fetch at 0x800000
// [RULE6] host interrupt latched in DMA event bit 0
// [RULE7] no new host interrupts until flag cleared
// [RULE8] board selects HPP or PCI by pin; code takes the mode from the select code and only checks the pin
// [RULE9] host-port boot holds CPU in reset
// [RULE10] PCI boot CPU idles until host interrupt
// [RULE11] PCI boot sets PLL multiply fifteen
// [RULE12] board drives config pins 000b, clock limit
// [RULE13] keep CPU below 750 MHz from ROM
// [RULE14] bootloader lives in ROM at 0x00100000
// [RULE15] select 0100b executes from 8-bit CS3 ROM
// [RULE16] select 0101b runs I2C master boot
// [RULE17] select 0110b runs I2C slave boot
// [RULE18] chip selects 2-5 as 8M windows
// [RULE19] DDR 512M window at E0000000
// [RULE20] PCI 256M window at 40000000
// [RULE21] config regions at 70000000 and 78000000
// [RULE22] no windows for chip selects 0,1
// [RULE23] other select codes are reserved
`timescale 1ns/100ps
`default_nettype none
module bms_top
	import bms_pkg::*;
(
	input  wire logic              sys_clk_in,
	input  wire logic              sys_rst_in,
	input  wire logic [3:0]        boot_select_pins_in,
	input  wire logic              pci_select_pin_in,
	input  wire logic [2:0]        general_config_pins_in,
	input  wire logic              host_to_cpu_interrupt_in,
	input  wire logic              host_irq_flag_clear_in,
	input  wire logic              dma_event_clear_in,
	input  wire logic              host_access_in,
	input  wire logic [31:0]       host_addr_in,
	input  wire logic [31:0]       sys_addr_in,
	output bms_pkg::bms_cpu_t      cpu_ctrl_out,
	output bms_pkg::bms_pll_t      pll_ctrl_out,
	output bms_pkg::bms_dec_t      dec_out,
	output bms_pkg::bms_mode_t     boot_mode_out,
	output logic                   boot_done_out,
	output logic                   host_access_grant_out,
	output logic                   host_access_block_out,
	output logic                   host_irq_flag_out,
	output logic                   dma_event0_out,
	output logic                   config_error_out
);

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [3:0] sel_sync;
	logic       pcisel_sync;
	logic [2:0] cfg_sync;
	logic       hirq_sync;

	// interrupt kept apart so strap jitter never delays it
	bms_sync3 #(.WIDTH(8)) u_sync (
		.sys_clk_in (sys_clk_in),
		.sys_rst_in (sys_rst_in),
		.pin_in     ({boot_select_pins_in, pci_select_pin_in, general_config_pins_in}),
		.level_out  ({sel_sync, pcisel_sync, cfg_sync})
	);

	bms_sync3 #(.WIDTH(1)) u_irq_sync (
		.sys_clk_in (sys_clk_in),
		.sys_rst_in (sys_rst_in),
		.pin_in     (host_to_cpu_interrupt_in),
		.level_out  (hirq_sync)
	);

	// ------------------------------------------------------------------
	// host-side and system address decode
	// ------------------------------------------------------------------
	bms_dec_t host_dec;

	bms_addr_dec u_host_dec (
		.sys_clk_in (sys_clk_in),
		.sys_rst_in (sys_rst_in),
		.addr_in    (host_addr_in),
		.dec_out    (host_dec)
	);

	bms_addr_dec u_sys_dec (
		.sys_clk_in (sys_clk_in),
		.sys_rst_in (sys_rst_in),
		.addr_in    (sys_addr_in),
		.dec_out    (dec_out)
	);

	// ------------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------------
	function automatic bms_mode_t decode_mode(input logic [3:0] sel);
		unique case (sel)
			BMS_SEL_NONE:     decode_mode = BMS_MODE_NONE;
			BMS_SEL_HOST_HPP: decode_mode = BMS_MODE_HOST_HPP;
			BMS_SEL_HOST_PCI: decode_mode = BMS_MODE_HOST_PCI;
			BMS_SEL_ROM8:     decode_mode = BMS_MODE_ROM8;
			BMS_SEL_I2C_MST:  decode_mode = BMS_MODE_I2C_MST;
			BMS_SEL_I2C_SLV:  decode_mode = BMS_MODE_I2C_SLV;
			default:          decode_mode = BMS_MODE_RSVD; // [RULE23]
		endcase
	endfunction

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_SETTLE,
		ST_SAMPLE,
		ST_HOST_WAIT,
		ST_RUN,
		ST_HALT
	} bms_state_t;

	bms_state_t state_q;
	bms_state_t state_d;
	bms_mode_t  mode_q;
	bms_mode_t  mode_d;
	logic [1:0] settle_q;
	logic [1:0] settle_d;
	logic       hirq_prev_q;
	logic       hirq_rise;
	logic       flag_q;
	logic       flag_d;
	logic       evt_q;
	logic       evt_d;
	logic       irq_take;
	logic       cfg_err_q;
	logic       cfg_err_d;
	logic       is_host;
	bms_mode_t  sampled_mode;
	bms_cpu_t   cpu_q;
	bms_cpu_t   cpu_d;
	bms_pll_t   pll_q;
	bms_pll_t   pll_d;
	logic       grant_q;
	logic       block_q;
	logic       acc_q;
	logic       grant_d;
	logic       block_d;
	logic       done_q;
	logic       done_d;

	assign sampled_mode = decode_mode(sel_sync);
	assign is_host      = (mode_q == BMS_MODE_HOST_HPP) || (mode_q == BMS_MODE_HOST_PCI);
	assign hirq_rise    = hirq_sync & ~hirq_prev_q;
	// flag still set refuses new host interrupts
	assign irq_take     = hirq_rise & ~flag_q; // [RULE7]

	// set wins over clear
	assign flag_d = irq_take | (flag_q & ~host_irq_flag_clear_in); // [RULE7]
	assign evt_d  = irq_take | (evt_q & ~dma_event_clear_in);       // [RULE6]

	assign settle_d = (state_q == ST_SETTLE) ? settle_q - 2'h1 : settle_q;

	always_comb begin
		state_d   = state_q;
		mode_d    = mode_q;
		cfg_err_d = cfg_err_q;
		unique case (state_q)
			ST_SETTLE: begin
				// boot starts on reset release without a command
				if (settle_q == 2'h0) begin // [RULE1]
					state_d = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				mode_d = sampled_mode;
				// pci select pin must agree with the host mode chosen
				cfg_err_d = ((sampled_mode == BMS_MODE_HOST_HPP) && pcisel_sync)
					|| ((sampled_mode == BMS_MODE_HOST_PCI)
						&& (!pcisel_sync || (cfg_sync != BMS_CFG_PINS_PCI))); // [RULE8] [RULE12]
				if (sampled_mode == BMS_MODE_RSVD) begin
					state_d = ST_HALT; // [RULE23]
				end else if ((sampled_mode == BMS_MODE_HOST_HPP) || (sampled_mode == BMS_MODE_HOST_PCI)) begin
					state_d = ST_HOST_WAIT; // [RULE3]
				end else begin
					state_d = ST_RUN;
				end
			end
			ST_HOST_WAIT: begin
				if (irq_take) begin
					state_d = ST_RUN; // [RULE5]
				end
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			ST_HALT: begin
				state_d = ST_HALT;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// cpu control per mode
	// ------------------------------------------------------------------
	always_comb begin
		cpu_d = '0;
		cpu_d.cpu_reset = 1'b1;
		unique case (state_d)
			ST_SETTLE, ST_SAMPLE, ST_HALT: begin
				cpu_d.cpu_reset = 1'b1;
			end
			ST_HOST_WAIT: begin
				cpu_d.cpu_stall = 1'b1; // [RULE3]
				if (mode_d == BMS_MODE_HOST_HPP) begin
					cpu_d.cpu_reset = 1'b1; // [RULE9]
				end else begin
					cpu_d.cpu_reset     = 1'b0;
					cpu_d.cpu_idle_wait = 1'b1; // [RULE10]
					cpu_d.fetch_addr    = BMS_ROM_ENTRY;
					cpu_d.bootloader_run = 1'b1;
				end
			end
			ST_RUN: begin
				cpu_d.cpu_reset = 1'b0;
				unique case (mode_d)
					BMS_MODE_ROM8: begin
						cpu_d.fetch_addr = BMS_CS3_ENTRY; // [RULE15]
					end
					BMS_MODE_I2C_MST, BMS_MODE_I2C_SLV: begin
						cpu_d.fetch_addr     = BMS_ROM_ENTRY; // [RULE14] [RULE16] [RULE17]
						cpu_d.bootloader_run = 1'b1;
					end
					default: begin
						cpu_d.fetch_addr = BMS_L2_ENTRY; // [RULE2] [RULE5]
					end
				endcase
			end
		endcase
	end

	// pci boot loads pll multiply by fifteen, predivide by one
	always_comb begin
		pll_d = pll_q;
		if ((state_q == ST_SAMPLE) && (sampled_mode == BMS_MODE_HOST_PCI)) begin
			pll_d.mult   = BMS_PLL_MULT_PCI;   // [RULE11] [RULE13]
			pll_d.pll_predivider_reg = BMS_PLL_PLL_PREDIVIDER_REG_PCI; // [RULE11]
			pll_d.load   = 1'b1;
		end else begin
			pll_d.load = 1'b0;
		end
	end

	// host access gating, registered one cycle behind the decode
	assign block_d = acc_q & is_host & host_dec.blocked_cfg; // [RULE4]
	assign grant_d = acc_q & ~block_d;                        // [RULE4]

	// done registered alongside the state so the output is a flop
	assign done_d  = (state_d == ST_RUN);

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_q     <= ST_SETTLE;
			mode_q      <= BMS_MODE_NONE;
			settle_q    <= BMS_SETTLE_CYCLES;
			hirq_prev_q <= 1'b0;
			flag_q      <= 1'b0;
			evt_q       <= 1'b0;
			cfg_err_q   <= 1'b0;
			cpu_q       <= '{cpu_reset: 1'b1, default: '0};
			pll_q       <= '0;
			acc_q       <= 1'b0;
			grant_q     <= 1'b0;
			block_q     <= 1'b0;
			done_q      <= 1'b0;
		end else begin
			state_q     <= state_d;
			mode_q      <= mode_d;
			settle_q    <= settle_d;
			hirq_prev_q <= hirq_sync;
			flag_q      <= flag_d;
			evt_q       <= evt_d;
			cfg_err_q   <= cfg_err_d;
			cpu_q       <= cpu_d;
			pll_q       <= pll_d;
			acc_q       <= host_access_in;
			grant_q     <= grant_d;
			block_q     <= block_d;
			done_q      <= done_d;
		end
	end

	assign cpu_ctrl_out          = cpu_q;
	assign pll_ctrl_out          = pll_q;
	assign boot_mode_out         = mode_q;
	assign boot_done_out         = done_q;
	assign host_access_grant_out = grant_q;
	assign host_access_block_out = block_q;
	assign host_irq_flag_out     = flag_q;
	assign dma_event0_out        = evt_q;
	assign config_error_out      = cfg_err_q;

endmodule
`default_nettype wire
